// file: verilog/ppfs_pkg.sv
// package for the port pin function select block
// assumes an 8-bit register address space and one system clock
package ppfs_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] PPFS_LOC_OFS = 8'hF1; // peripheral_location_config
  localparam logic [7:0] PPFS_SEL_OFS = 8'hF5; // port2_function_and_port1_priority
  localparam logic [7:0] PPFS_DIR_OFS = 8'hFD; // port0_pin_direction

  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [7:0] PPFS_SEL_RST = 8'h00;
  localparam logic [7:0] PPFS_DIR_RST = 8'h00;
  localparam logic [7:0] PPFS_LOC_RST = 8'h00;
  localparam logic [7:0] PPFS_SEL_MASK = 8'h7F; // top bit reads as zero
  localparam logic [7:0] PPFS_LOC_MASK = 8'h73; // unused bits read as zero

  // ****************************************
  // field positions, priority / function select
  // ****************************************
  localparam int PPFS_PRI_SERIAL_PAIR = 6; // serial_pair_priority
  localparam int PPFS_PRI_S1_T3 = 5; // serial1_vs_timer3_priority
  localparam int PPFS_PRI_T1_T4 = 4; // timer1_vs_timer4_priority
  localparam int PPFS_PRI_S0_T1 = 3; // serial0_vs_timer1_priority
  localparam int PPFS_FN_LSB = 0; // port2 pin 4,3,0 function bits 2:0

  // ****************************************
  // field positions, location select
  // ****************************************
  localparam int PPFS_LOC_T1 = 6;
  localparam int PPFS_LOC_T3 = 5;
  localparam int PPFS_LOC_T4 = 4;
  localparam int PPFS_LOC_S1 = 1;
  localparam int PPFS_LOC_S0 = 0;

  // owner of a port1 pin
  typedef enum logic [2:0] {
    PPFS_OWN_NONE = 3'h0,
    PPFS_OWN_SERIAL0 = 3'h1,
    PPFS_OWN_SERIAL1 = 3'h2,
    PPFS_OWN_TIMER1 = 3'h3,
    PPFS_OWN_TIMER3 = 3'h4,
    PPFS_OWN_TIMER4 = 3'h5
  } ppfs_owner_t;

endpackage

// file: verilog/ppfs_top.sv
// port pin function select: priority arbitration of port1 pins,
// port2 function select bits and port0 direction register
// assumes claims come from peripherals on ref_clk_i, no synchronisers
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module ppfs_top
  import ppfs_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [PINS-1:0] serial0_alt1_i,
  input wire logic [PINS-1:0] serial0_alt2_i,
  input wire logic [PINS-1:0] serial1_alt1_i,
  input wire logic [PINS-1:0] serial1_alt2_i,
  input wire logic [PINS-1:0] timer1_alt1_i,
  input wire logic [PINS-1:0] timer1_alt2_i,
  input wire logic [PINS-1:0] timer3_alt1_i,
  input wire logic [PINS-1:0] timer3_alt2_i,
  input wire logic [PINS-1:0] timer4_alt1_i,
  input wire logic [PINS-1:0] timer4_alt2_i,
  output logic [7:0] rdata_o,
  output logic [7:0] port0_dir_o,
  output logic [2:0] port2_function_o,
  output logic [3*PINS-1:0] port1_owner_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] sel; // function and priority bits
    logic [7:0] dir; // port0 direction
    logic [7:0] loc; // location selects
    logic [7:0] rdata; // read data, one cycle
    logic [3*PINS-1:0] owner; // owner per port1 pin
  } ppfs_state_t;

  ppfs_state_t st_q;
  ppfs_state_t st_d;
  logic [3*PINS-1:0] owner_w; // arbitration result per pin

  // ****************************************
  // per-pin arbitration
  // ****************************************
  // the pair graph is a tree, so at least one claimant always survives;
  // pairs with no priority bit fall back to a fixed order
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    logic c_s0; // claims after location select
    logic c_s1;
    logic c_t1;
    logic c_t3;
    logic c_t4;
    logic k_s0; // claimant beaten by a pair rule
    logic k_s1;
    logic k_t1;
    logic k_t3;
    logic k_t4;
    ppfs_owner_t win;

    // location bit chooses alternative
    assign c_s0 = st_q.loc[PPFS_LOC_S0] ? serial0_alt2_i[i] : serial0_alt1_i[i];
    assign c_s1 = st_q.loc[PPFS_LOC_S1] ? serial1_alt2_i[i] : serial1_alt1_i[i];
    assign c_t1 = st_q.loc[PPFS_LOC_T1] ? timer1_alt2_i[i] : timer1_alt1_i[i];
    assign c_t3 = st_q.loc[PPFS_LOC_T3] ? timer3_alt2_i[i] : timer3_alt1_i[i];
    assign c_t4 = st_q.loc[PPFS_LOC_T4] ? timer4_alt2_i[i] : timer4_alt1_i[i];

    // serial pair and serial0 versus timer1
    assign k_s0 = (c_s0 & c_s1 & st_q.sel[PPFS_PRI_SERIAL_PAIR])
                | (c_s0 & c_t1 & st_q.sel[PPFS_PRI_S0_T1]);
    // serial1 loses to serial0 or timer3
    assign k_s1 = (c_s0 & c_s1 & ~st_q.sel[PPFS_PRI_SERIAL_PAIR])
                | (c_s1 & c_t3 & st_q.sel[PPFS_PRI_S1_T3]);
    // timer3 loses to serial1
    assign k_t3 = c_s1 & c_t3 & ~st_q.sel[PPFS_PRI_S1_T3];
    // timer1 loses to timer4 or serial0
    assign k_t1 = (c_t1 & c_t4 & st_q.sel[PPFS_PRI_T1_T4])
                | (c_s0 & c_t1 & ~st_q.sel[PPFS_PRI_S0_T1]);
    // timer4 loses to timer1
    assign k_t4 = c_t1 & c_t4 & ~st_q.sel[PPFS_PRI_T1_T4];

    // pick the first surviving claimant
    always_comb begin
      if (c_s0 && !k_s0) begin
        win = PPFS_OWN_SERIAL0;
      end else if (c_s1 && !k_s1) begin
        win = PPFS_OWN_SERIAL1;
      end else if (c_t1 && !k_t1) begin
        win = PPFS_OWN_TIMER1;
      end else if (c_t3 && !k_t3) begin
        win = PPFS_OWN_TIMER3;
      end else if (c_t4 && !k_t4) begin
        win = PPFS_OWN_TIMER4;
      end else begin
        win = PPFS_OWN_NONE;
      end
    end

    assign owner_w[3*i +: 3] = win;
  end

  // ****************************************
  // next state
  // ****************************************
  // register writes, one-cycle read data, owner latch
  always_comb begin
    st_d = st_q;
    st_d.rdata = 8'h00; // read data stands one cycle only
    st_d.owner = owner_w;
    if (wr_i) begin
      case (addr_i)
        PPFS_SEL_OFS: begin
          st_d.sel = wdata_i & PPFS_SEL_MASK;
        end
        PPFS_DIR_OFS: begin
          st_d.dir = wdata_i;
        end
        PPFS_LOC_OFS: begin
          st_d.loc = wdata_i & PPFS_LOC_MASK;
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        PPFS_SEL_OFS: begin
          st_d.rdata = st_q.sel;
        end
        PPFS_DIR_OFS: begin
          st_d.rdata = st_q.dir;
        end
        PPFS_LOC_OFS: begin
          st_d.rdata = st_q.loc;
        end
        default: begin
          st_d.rdata = 8'h00; // unmapped reads answer zero
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // synchronous reset clears everything
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q.sel <= PPFS_SEL_RST;
      st_q.dir <= PPFS_DIR_RST;
      st_q.loc <= PPFS_LOC_RST;
      st_q.rdata <= 8'h00;
      st_q.owner <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // plain wires off the flip-flops
  assign rdata_o = st_q.rdata;
  assign port0_dir_o = st_q.dir;
  assign port2_function_o = st_q.sel[PPFS_FN_LSB +: 3];
  assign port1_owner_o = st_q.owner;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_sel_write;
    wr_i && addr_i == PPFS_SEL_OFS;
  endsequence

  sequence s_sel_read;
    rd_i && addr_i == PPFS_SEL_OFS;
  endsequence

  sequence s_dir_write;
    wr_i && addr_i == PPFS_DIR_OFS;
  endsequence

  sequence s_dir_read;
    rd_i && addr_i == PPFS_DIR_OFS;
  endsequence

  a_serial_pair_win: assert property (
    g_pin[0].c_s0 && g_pin[0].c_s1 |=> port1_owner_o[2:0] !=
      ($past(st_q.sel[PPFS_PRI_SERIAL_PAIR]) ? PPFS_OWN_SERIAL0 : PPFS_OWN_SERIAL1))
    else $error("serial pair winner wrong");

  a_s1_t3_win: assert property (
    g_pin[0].c_s1 && g_pin[0].c_t3 |=> port1_owner_o[2:0] !=
      ($past(st_q.sel[PPFS_PRI_S1_T3]) ? PPFS_OWN_SERIAL1 : PPFS_OWN_TIMER3))
    else $error("serial1 timer3 winner wrong");

  a_t1_t4_win: assert property (
    g_pin[0].c_t1 && g_pin[0].c_t4 |=> port1_owner_o[2:0] !=
      ($past(st_q.sel[PPFS_PRI_T1_T4]) ? PPFS_OWN_TIMER1 : PPFS_OWN_TIMER4))
    else $error("timer1 timer4 winner wrong");

  a_s0_t1_win: assert property (
    g_pin[0].c_s0 && g_pin[0].c_t1 |=> port1_owner_o[2:0] !=
      ($past(st_q.sel[PPFS_PRI_S0_T1]) ? PPFS_OWN_SERIAL0 : PPFS_OWN_TIMER1))
    else $error("serial0 timer1 winner wrong");

  a_dir_write: assert property (
    wr_i && addr_i == PPFS_DIR_OFS |=> port0_dir_o == $past(wdata_i))
    else $error("direction write lost");

  // reset clearing runs with the default disable switched off, else it never fires
  a_dir_reset: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    rst_i |=> port0_dir_o == PPFS_DIR_RST)
    else $error("direction not cleared by reset");

  a_loc_alt2: assert property (
    st_q.loc[PPFS_LOC_S0] && serial0_alt2_i[0] && !g_pin[0].c_s1 && !g_pin[0].c_t1
      |=> port1_owner_o[2:0] == PPFS_OWN_SERIAL0)
    else $error("serial0 alternative two not granted");

  a_fn_readback: assert property (
    s_sel_write ##1 (s_sel_read and !wr_i)
      |=> rdata_o == ($past(wdata_i, 2) & PPFS_SEL_MASK)
        && port2_function_o == $past(wdata_i[2:0], 2))
    else $error("function select readback wrong");

  // a direction read returns the register as it stood at the strobe
  a_dir_readback: assert property (
    s_dir_read |=> rdata_o == $past(port0_dir_o))
    else $error("direction readback wrong");

  // a read right behind a write already sees the new direction
  a_dir_wr_rd: assert property (
    s_dir_write ##1 (s_dir_read and !wr_i) |=> rdata_o == $past(wdata_i, 2))
    else $error("direction write then read wrong");

  // direction bits only move on a direction write
  a_dir_hold: assert property (
    !(wr_i && addr_i == PPFS_DIR_OFS) |=> $stable(port0_dir_o))
    else $error("direction changed without write");

  // function bits only move on a select write
  a_fn_hold: assert property (
    !(wr_i && addr_i == PPFS_SEL_OFS) |=> $stable(port2_function_o))
    else $error("function select changed without write");

  // the low select bits read back as the function outputs
  a_fn_bits_read: assert property (
    s_sel_read |=> rdata_o[2:0] == $past(port2_function_o))
    else $error("function bits readback wrong");

  // ****************************************
  // exact owners when only one pair claims, or when nobody claims
  // ****************************************
  // serial pair alone: bit 6 names the owner outright
  a_serial_pair_only: assert property (
    g_pin[0].c_s0 && g_pin[0].c_s1 && !g_pin[0].c_t1 && !g_pin[0].c_t3 && !g_pin[0].c_t4
      |=> port1_owner_o[2:0] ==
        ($past(st_q.sel[PPFS_PRI_SERIAL_PAIR]) ? PPFS_OWN_SERIAL1 : PPFS_OWN_SERIAL0))
    else $error("serial pair owner wrong");

  // serial1 and timer3 alone: bit 5 names the owner
  a_s1_t3_only: assert property (
    g_pin[0].c_s1 && g_pin[0].c_t3 && !g_pin[0].c_s0 && !g_pin[0].c_t1 && !g_pin[0].c_t4
      |=> port1_owner_o[2:0] ==
        ($past(st_q.sel[PPFS_PRI_S1_T3]) ? PPFS_OWN_TIMER3 : PPFS_OWN_SERIAL1))
    else $error("serial1 timer3 owner wrong");

  // timer1 and timer4 alone: bit 4 names the owner
  a_t1_t4_only: assert property (
    g_pin[0].c_t1 && g_pin[0].c_t4 && !g_pin[0].c_s0 && !g_pin[0].c_s1 && !g_pin[0].c_t3
      |=> port1_owner_o[2:0] ==
        ($past(st_q.sel[PPFS_PRI_T1_T4]) ? PPFS_OWN_TIMER4 : PPFS_OWN_TIMER1))
    else $error("timer1 timer4 owner wrong");

  // serial0 and timer1 alone: bit 3 names the owner
  a_s0_t1_only: assert property (
    g_pin[0].c_s0 && g_pin[0].c_t1 && !g_pin[0].c_s1 && !g_pin[0].c_t3 && !g_pin[0].c_t4
      |=> port1_owner_o[2:0] ==
        ($past(st_q.sel[PPFS_PRI_S0_T1]) ? PPFS_OWN_TIMER1 : PPFS_OWN_SERIAL0))
    else $error("serial0 timer1 owner wrong");

  // a pin that nobody claims at its selected location stays free
  a_owner_none: assert property (
    !g_pin[0].c_s0 && !g_pin[0].c_s1 && !g_pin[0].c_t1 && !g_pin[0].c_t3 && !g_pin[0].c_t4
      |=> port1_owner_o[2:0] == PPFS_OWN_NONE)
    else $error("unclaimed pin given an owner");

endmodule

// file: test/ppfs_top_tb_top.sv
// testbench for the port pin function select block
// assumes ppfs_pkg is compiled first; the bench drives every port itself
`timescale 1ns/1ps
module ppfs_top_tb_top;
  import ppfs_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] claim [10] = '{default: 8'h00}; // even index alt1, odd index alt2
  logic [7:0] rdata_o;
  logic [7:0] port0_dir_o;
  logic [2:0] port2_function_o;
  logic [23:0] port1_owner_o;
  int miscompares = 0;
  int check_count = 0;
  // pair table: claim index a, claim index b, priority bit, owner codes
  int pa [4] = '{0, 2, 4, 0};
  int pb [4] = '{2, 6, 8, 4};
  int pbit [4] = '{6, 5, 4, 3};
  logic [2:0] ca [4] = '{3'h1, 3'h2, 3'h3, 3'h1};
  logic [2:0] cb [4] = '{3'h2, 3'h4, 3'h5, 3'h3};
  // location bit of serial0, serial1, timer1, timer3, timer4
  int lbit [5] = '{PPFS_LOC_S0, PPFS_LOC_S1, PPFS_LOC_T1, PPFS_LOC_T3, PPFS_LOC_T4};

  always #5 ref_clk_i = ~ref_clk_i;

  ppfs_top #(.PINS(8)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i),
    .serial0_alt1_i(claim[0]), .serial0_alt2_i(claim[1]),
    .serial1_alt1_i(claim[2]), .serial1_alt2_i(claim[3]),
    .timer1_alt1_i(claim[4]), .timer1_alt2_i(claim[5]),
    .timer3_alt1_i(claim[6]), .timer3_alt2_i(claim[7]),
    .timer4_alt1_i(claim[8]), .timer4_alt2_i(claim[9]),
    .rdata_o(rdata_o), .port0_dir_o(port0_dir_o),
    .port2_function_o(port2_function_o), .port1_owner_o(port1_owner_o)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, then drop to zero
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(24'(rdata_o), 24'(exp));
    @(negedge ref_clk_i);
    chk(24'(rdata_o), 24'h000000);
  endtask

  // write then read with no gap; the read must already see the new value
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(24'(rdata_o), 24'(exp));
  endtask

  // owner is registered one edge behind the claims; only pins 0 and 7 claim
  // returns on a rising edge so the caller changes claims there
  task automatic own(input logic [2:0] exp);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(port1_owner_o, {exp, 18'h00000, exp});
    @(posedge ref_clk_i);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rd(PPFS_SEL_OFS, 8'h00);
    rd(PPFS_DIR_OFS, 8'h00);
    chk(24'(port0_dir_o), 24'h000000);
    wr(PPFS_DIR_OFS, 8'hA5);
    rd(PPFS_DIR_OFS, 8'hA5);
    chk(24'(port0_dir_o), 24'h0000A5);
    wrrd(PPFS_DIR_OFS, 8'h3C, 8'h3C);
    wr(PPFS_SEL_OFS, 8'hFF);
    rd(PPFS_SEL_OFS, 8'h7F);
    chk(24'(port2_function_o), 24'h000007);
    wrrd(PPFS_SEL_OFS, 8'hFD, 8'h7D);
    chk(24'(port2_function_o), 24'h000005);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    $display("test registers done");
  endtask

  // each pair claims pins 0 and 7 at once; the priority bit picks the owner
  task automatic t_prio();
    for (int p = 0; p < 4; p++) begin
      for (int v = 0; v < 2; v++) begin
        wr(PPFS_SEL_OFS, 8'(v << pbit[p]));
        claim[pa[p]] <= 8'h81;
        claim[pb[p]] <= 8'h81;
        own(v ? cb[p] : ca[p]);
        claim[pa[p]] <= 8'h00;
        claim[pb[p]] <= 8'h00;
      end
    end
    $display("test priority done");
  endtask

  // each unit moved to its second location ignores first-location claims
  task automatic t_loc();
    wr(PPFS_LOC_OFS, 8'hFF);
    rd(PPFS_LOC_OFS, 8'h73);
    for (int k = 0; k < 5; k++) begin
      wr(PPFS_LOC_OFS, 8'(1 << lbit[k]));
      claim[2*k] <= 8'h81;
      own(3'h0);
      claim[2*k] <= 8'h00;
      claim[2*k+1] <= 8'h81;
      own(3'(k + 1));
      claim[2*k+1] <= 8'h00;
    end
    wr(PPFS_LOC_OFS, 8'h00);
    $display("test location done");
  endtask

  // a reset in mid-run clears the direction and function bits
  task automatic t_rst();
    wr(PPFS_SEL_OFS, 8'h07);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(24'(port0_dir_o), 24'(PPFS_DIR_RST));
    chk(24'(port2_function_o), 24'h000000);
    rd(PPFS_SEL_OFS, PPFS_SEL_RST);
    $display("test reset done");
  endtask

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_prio();
    t_loc();
    t_rst();
    wrap_up();
  end
endmodule
